// File: hdl/twm_consts.svh
// Purpose: Constants of the two-wire bus master: offsets, fields, resets, timing
// Assumes: 100 MHz system clock
// Notes:   Definitions only
`ifndef TWM_CONSTS_SVH
`define TWM_CONSTS_SVH

// ******************************
// Register offsets
// ******************************
`define TWM_OFS_CTRL 8'h00
`define TWM_OFS_ADDR 8'h04
`define TWM_OFS_TXD 8'h08
`define TWM_OFS_RXD 8'h0c
`define TWM_OFS_STAT 8'h10
`define TWM_OFS_MCODE 8'h14

// ******************************
// Field positions
// ******************************
`define TWM_B_GO 0
`define TWM_B_TEN 1
`define TWM_B_RD 2
`define TWM_B_POLL 3
`define TWM_B_HS 4
`define TWM_B_SMB 5
`define TWM_B_RATE 6
`define TWM_B_BUSY 0
`define TWM_B_ACT 1
`define TWM_B_DONE 2
`define TWM_B_NACK 3
`define TWM_B_ARB 4
`define TWM_B_TMO 5

// ******************************
// Reset values and fixed patterns
// ******************************
`define TWM_RST_ADDR 10'h000
`define TWM_RST_TXD 8'h00
`define TWM_RST_MCODE 3'h1
`define TWM_GRP_TEN 5'h1e
`define TWM_GRP_MCODE 5'h01

// ******************************
// Timing
// ******************************
`define TWM_CLK_NS 10
`define TWM_KHZ_STD 100
`define TWM_KHZ_FAST 400
`define TWM_KHZ_FMP 1000
`define TWM_KHZ_HS 3400
`define TWM_SMB_MIN_KHZ 10
`define TWM_SMB_TMO_MS 35
`define TWM_QW 9
`define TWM_TMO_W 22

`endif

// File: hdl/twm_master.sv
// Purpose: Two-wire serial bus master with register port
// Assumes: Open-drain pins resolved outside; 100 MHz sys_clk
// Notes:   One data byte per transfer; read bytes end with no-acknowledge
`timescale 1ns/1ps
`include "twm_consts.svh"
module twm_master import twm_pkg::*; #(
   parameter int TMO_CYC = `TWM_SMB_TMO_MS * 1000000 / `TWM_CLK_NS
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Bus pins
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n
);
   localparam int DEN = 4 * `TWM_CLK_NS;
   localparam int Q_STD = (1000000 + DEN * `TWM_KHZ_STD - 1) / (DEN * `TWM_KHZ_STD);
   localparam int Q_FAST = (1000000 + DEN * `TWM_KHZ_FAST - 1) / (DEN * `TWM_KHZ_FAST);
   localparam int Q_FMP = (1000000 + DEN * `TWM_KHZ_FMP - 1) / (DEN * `TWM_KHZ_FMP);
   localparam int Q_HS = (1000000 + DEN * `TWM_KHZ_HS - 1) / (DEN * `TWM_KHZ_HS);

   twm_ctrl_s ctrl, next_ctrl;
   twm_stat_s stat, next_stat, ev;
   logic [9:0] addr, next_addr;
   logic [7:0] txd, next_txd, rxd, next_rxd;
   logic [2:0] mcode, next_mcode;
   logic [15:0] next_rdata;
   logic go;
   twm_st_e st, next_st;
   twm_sq_e sq, next_sq;
   logic [1:0] ph, next_ph;
   logic [3:0] bidx, next_bidx;
   logic [8:0] sh, next_sh;
   logic [`TWM_QW-1:0] qcnt, next_qcnt, qlen;
   logic [`TWM_TMO_W-1:0] lowcnt, next_lowcnt;
   logic hs_on, next_hs_on, busy, next_busy;
   logic next_scl_oe_n, next_sda_oe_n;
   logic scl_s, scl_p, sda_s, sda_p;
   logic wait_hi, tick, own_arb, start_det, stop_det, tmo_hit, ack;

   // ******************************
   // Line sampling and bus state
   // ******************************
   twm_sync u_scl (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .pin(scl_i), .lvl(scl_s),
      .prev(scl_p));
   twm_sync u_sda (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .pin(sda_i), .lvl(sda_s),
      .prev(sda_p));

   always_comb begin
      start_det = scl_s && scl_p && sda_p && !sda_s;
      stop_det = scl_s && scl_p && !sda_p && sda_s;
      next_busy = busy;
      if (start_det) begin
         next_busy = 1'h1;
      end else if (stop_det) begin
         next_busy = 1'h0;
      end
   end

   // ******************************
   // Register port
   // ******************************
   always_comb begin
      next_ctrl = ctrl;
      next_addr = addr;
      next_txd = txd;
      next_mcode = mcode;
      next_rdata = 16'h0000;
      go = 1'h0;
      next_stat = stat | ev;
      if (reg_wr) begin
         case (reg_addr)
            `TWM_OFS_CTRL: begin
               next_ctrl.ten = reg_wdata[`TWM_B_TEN];
               next_ctrl.rd = reg_wdata[`TWM_B_RD];
               next_ctrl.poll = reg_wdata[`TWM_B_POLL];
               next_ctrl.hs = reg_wdata[`TWM_B_HS];
               next_ctrl.smb = reg_wdata[`TWM_B_SMB];
               next_ctrl.rate = reg_wdata[`TWM_B_RATE +: 2];
               go = reg_wdata[`TWM_B_GO] && (st == ST_IDLE) && !busy;
            end
            `TWM_OFS_ADDR: next_addr = reg_wdata[9:0];
            `TWM_OFS_TXD: next_txd = reg_wdata[7:0];
            `TWM_OFS_MCODE: begin
               if (reg_wdata[2:0] != 3'h0) begin
                  next_mcode = reg_wdata[2:0];
               end
            end
            // Clear-on-one; a new event in the same cycle survives
            `TWM_OFS_STAT: next_stat = (stat & ~reg_wdata[`TWM_B_DONE +: 4]) | ev;
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            // Fields read back where they are written; GO reads as zero
            `TWM_OFS_CTRL: next_rdata = {8'h00, ctrl, 1'h0};
            `TWM_OFS_ADDR: next_rdata = {6'h00, addr};
            `TWM_OFS_TXD: next_rdata = {8'h00, txd};
            `TWM_OFS_RXD: next_rdata = {8'h00, rxd};
            `TWM_OFS_STAT: next_rdata = {10'h000, stat, st != ST_IDLE, busy};
            `TWM_OFS_MCODE: next_rdata = {13'h0000, mcode};
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl <= '0;
         addr <= `TWM_RST_ADDR;
         txd <= `TWM_RST_TXD;
         mcode <= `TWM_RST_MCODE;
         stat <= '0;
         reg_rdata <= 16'h0000;
         busy <= 1'h0;
      end else if (ce) begin
         ctrl <= next_ctrl;
         addr <= next_addr;
         txd <= next_txd;
         mcode <= next_mcode;
         stat <= next_stat;
         reg_rdata <= next_rdata;
         busy <= next_busy;
      end
   end

   // ******************************
   // Bit and byte engine
   // ******************************
   function automatic logic [8:0] load_byte(twm_sq_e s, twm_ctrl_s c, logic [9:0] a,
      logic [7:0] d, logic [2:0] m);
      logic [8:0] b;
      b = 9'h1ff;
      case (s)
         SQ_MCODE: b = {`TWM_GRP_MCODE, m, 1'h1};
         SQ_ADR1: b = c.ten ? {`TWM_GRP_TEN, a[9:8], c.rd, 1'h1}
                            : {a[6:0], c.rd, 1'h1};
         SQ_ADR2: b = {a[7:0], 1'h1};
         SQ_DATA: b = c.rd ? 9'h1ff : {d, 1'h1};
         default: b = 9'h1ff;
      endcase
      return b;
   endfunction

   always_comb begin
      case (1'h1)
         hs_on: qlen = `TWM_QW'(Q_HS);
         ctrl.smb: qlen = `TWM_QW'(Q_STD);
         ctrl.rate == 2'h1: qlen = `TWM_QW'(Q_FAST);
         ctrl.rate == 2'h2: qlen = `TWM_QW'(Q_FMP);
         default: qlen = `TWM_QW'(Q_STD);
      endcase
   end

   // Released clock still low means a slave stretches it
   assign wait_hi = scl_oe_n && !scl_s;
   assign tick = (qcnt == '0) && !wait_hi;
   assign own_arb = (bidx < 4'h8) && (sq != SQ_DATA || !ctrl.rd) && !hs_on;
   assign tmo_hit = ctrl.smb && (st != ST_IDLE) && (lowcnt == `TWM_TMO_W'(TMO_CYC - 1));
   assign ack = !sh[0];

   always_comb begin
      next_st = st;
      next_sq = sq;
      next_ph = ph;
      next_bidx = bidx;
      next_sh = sh;
      next_rxd = rxd;
      next_hs_on = hs_on;
      next_scl_oe_n = scl_oe_n;
      next_sda_oe_n = sda_oe_n;
      next_qcnt = (qcnt != '0) ? qcnt - `TWM_QW'(1) : qcnt;
      next_lowcnt = (ctrl.smb && !scl_s && st != ST_IDLE) ? lowcnt + `TWM_TMO_W'(1) : '0;
      ev = '0;
      if (tick) begin
         next_qcnt = qlen - `TWM_QW'(1);
         next_ph = ph + 2'h1;
      end
      case (st)
         ST_IDLE: begin
            next_scl_oe_n = 1'h1;
            next_sda_oe_n = 1'h1;
            next_ph = 2'h0;
            next_qcnt = qlen;
            if (go) begin
               next_st = ST_START;
               next_hs_on = 1'h0;
               next_sq = reg_wdata[`TWM_B_HS] ? SQ_MCODE : SQ_ADR1;
            end
         end
         ST_START: begin
            if (tick) begin
               case (ph)
                  2'h0: next_scl_oe_n = 1'h1;
                  2'h1: next_sda_oe_n = 1'h0;
                  2'h2: next_scl_oe_n = 1'h0;
                  default: begin
                     next_st = ST_BYTE;
                     next_bidx = 4'h0;
                     next_sh = load_byte(sq, ctrl, addr, txd, mcode);
                  end
               endcase
            end
         end
         ST_BYTE: begin
            if (tick) begin
               case (ph)
                  2'h0: begin
                     if (bidx != 4'h9) begin
                        next_sda_oe_n = sh[8];
                     end else begin
                        next_ph = 2'h0;
                        next_bidx = 4'h0;
                        next_st = ST_STOP;
                        next_sda_oe_n = 1'h0;
                        case (sq)
                           SQ_MCODE: begin
                              next_hs_on = 1'h1;
                              next_st = ST_START;
                              next_sda_oe_n = 1'h1;
                              next_sq = SQ_ADR1;
                           end
                           SQ_ADR1, SQ_ADR2: begin
                              if (ack) begin
                                 next_st = ST_BYTE;
                                 next_sq = (sq == SQ_ADR1 && ctrl.ten) ? SQ_ADR2 : SQ_DATA;
                                 next_sh = load_byte(next_sq, ctrl, addr, txd, mcode);
                              end else if (ctrl.poll) begin
                                 next_st = ST_START;
                                 next_sda_oe_n = 1'h1;
                                 next_sq = SQ_ADR1;
                              end else begin
                                 ev.nack = 1'h1;
                              end
                           end
                           default: begin
                              if (ctrl.rd) begin
                                 next_rxd = sh[8:1];
                              end else if (!ack) begin
                                 ev.nack = 1'h1;
                              end
                           end
                        endcase
                     end
                  end
                  2'h1: next_scl_oe_n = 1'h1;
                  2'h2: begin
                     next_sh = {sh[7:0], sda_s};
                     next_bidx = bidx + 4'h1;
                     if (own_arb && sda_oe_n && !sda_s) begin
                        next_st = ST_LOST;
                        next_scl_oe_n = 1'h1;
                     end
                  end
                  default: next_scl_oe_n = 1'h0;
               endcase
            end
         end
         ST_STOP: begin
            if (tick) begin
               case (ph)
                  2'h0: next_sda_oe_n = 1'h0;
                  2'h1: next_scl_oe_n = 1'h1;
                  2'h2: next_sda_oe_n = 1'h1;
                  default: begin
                     next_st = ST_IDLE;
                     ev.done = 1'h1;
                  end
               endcase
            end
         end
         ST_LOST: begin
            next_scl_oe_n = 1'h1;
            next_sda_oe_n = 1'h1;
            if (!busy) begin
               next_st = ST_IDLE;
               ev.arb = 1'h1;
            end
         end
         default: next_st = ST_IDLE;
      endcase
      if (tmo_hit) begin
         next_st = ST_IDLE;
         next_scl_oe_n = 1'h1;
         next_sda_oe_n = 1'h1;
         ev.tmo = 1'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st <= ST_IDLE;
         sq <= SQ_ADR1;
         ph <= 2'h0;
         bidx <= 4'h0;
         sh <= 9'h1ff;
         rxd <= 8'h00;
         hs_on <= 1'h0;
         qcnt <= '0;
         lowcnt <= '0;
         scl_oe_n <= 1'h1;
         sda_oe_n <= 1'h1;
         scl_o <= 1'h0;
         sda_o <= 1'h0;
      end else if (ce) begin
         st <= next_st;
         sq <= next_sq;
         ph <= next_ph;
         bidx <= next_bidx;
         sh <= next_sh;
         rxd <= next_rxd;
         hs_on <= next_hs_on;
         qcnt <= next_qcnt;
         lowcnt <= next_lowcnt;
         scl_oe_n <= next_scl_oe_n;
         sda_oe_n <= next_sda_oe_n;
         scl_o <= 1'h0;
         sda_o <= 1'h0;
      end
   end

   // ******************************
   // Checks
   // ******************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   property p_start;
      ce && st == ST_START && !next_sda_oe_n && sda_oe_n |=> !sda_oe_n && scl_oe_n;
   endproperty
   a_start: assert property (p_start) else $error("start edge without clock high");
   property p_busy;
      ce && start_det |=> busy;
   endproperty
   a_busy: assert property (p_busy) else $error("bus not busy after start");
   property p_steady;
      st == ST_BYTE && $changed(sda_oe_n) |-> !scl_oe_n && !$past(scl_oe_n);
   endproperty
   a_steady: assert property (p_steady) else $error("data moved while clock high");
   property p_stop;
      st == ST_STOP && $rose(sda_oe_n) |-> scl_oe_n && $past(scl_oe_n);
   endproperty
   a_stop: assert property (p_stop) else $error("stop edge without clock high");
   property p_stretch;
      ce && wait_hi && st != ST_IDLE && qcnt == '0 |=> qcnt == '0 && ph == $past(ph);
   endproperty
   a_stretch: assert property (p_stretch) else $error("advanced while clock held low");
   property p_nack;
      ce && st == ST_BYTE && tick && ph == 2'h0 && bidx == 4'h9 && sq == SQ_ADR1
         && !ack && !ctrl.poll && !tmo_hit |=> st == ST_STOP ##1 stat.nack;
   endproperty
   a_nack: assert property (p_nack) else $error("no stop or error on address nack");
   property p_mcode;
      mcode != 3'h0;
   endproperty
   a_mcode: assert property (p_mcode) else $error("master code zero");
   property p_drive;
      scl_o == 1'h0 && sda_o == 1'h0;
   endproperty
   a_drive: assert property (p_drive) else $error("line driven high");
   property p_lost;
      ce && st == ST_BYTE && ph == 2'h2 && tick && own_arb && sda_oe_n && !sda_s && !tmo_hit
         |=> st == ST_LOST && scl_oe_n && sda_oe_n;
   endproperty
   a_lost: assert property (p_lost) else $error("arbitration loss missed");
   property p_tmo;
      ce && tmo_hit |=> st == ST_IDLE && scl_oe_n && sda_oe_n ##1 stat.tmo;
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout did not reset");
endmodule

// File: hdl/twm_pkg.sv
// Purpose: Types of the two-wire bus master
// Assumes: Nothing
// Notes:   Constants live in twm_consts.svh
package twm_pkg;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_START = 5'h02,
      ST_BYTE = 5'h04,
      ST_STOP = 5'h08,
      ST_LOST = 5'h10
   } twm_st_e;

   typedef enum logic [3:0] {
      SQ_MCODE = 4'h1,
      SQ_ADR1 = 4'h2,
      SQ_ADR2 = 4'h4,
      SQ_DATA = 4'h8
   } twm_sq_e;

   typedef struct packed {
      logic [1:0] rate;
      logic smb;
      logic hs;
      logic poll;
      logic rd;
      logic ten;
   } twm_ctrl_s;

   typedef struct packed {
      logic tmo;
      logic arb;
      logic nack;
      logic done;
   } twm_stat_s;

endpackage

// File: hdl/twm_sync.sv
// Purpose: Two-flop synchroniser for one bus line, with a delayed copy
// Assumes: Bus line idles released (high)
// Notes:   Only the second flop and later are visible outside
`timescale 1ns/1ps
module twm_sync (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   // Line
   input wire logic pin,
   output logic lvl,
   output logic prev
);
   logic meta;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         meta <= 1'h1;
         lvl <= 1'h1;
         prev <= 1'h1;
      end else if (ce) begin
         meta <= pin;
         lvl <= meta;
         prev <= lvl;
      end
   end
endmodule

// File: verification/twm_slave_model.sv
// Purpose: Behavioural slave on the shared two-wire bus
// Assumes: Both lines have pull-ups; master changes data only while clock low
// Notes:   Pulls lines low only; stretch and address refusal set by the bench
`timescale 1ns/1ps
module twm_slave_model (
   // Bus lines
   input wire logic scl,
   input wire logic sda,
   output logic scl_pull,
   output logic sda_pull,
   // Setup from the bench
   input wire logic [9:0] own,
   input wire logic ten,
   input wire logic [7:0] rd_byte,
   input wire logic signed [31:0] nack_n,
   input wire logic signed [31:0] stretch_ns,
   // What was seen on the wire
   output logic [7:0] rx,
   output logic [7:0] b0,
   output logic [7:0] prev_b0,
   output int starts,
   output int per_ns,
   output logic act
);
   int bitc;
   int k;
   int nk;
   logic [7:0] sh;
   logic sel;
   logic rw;
   logic rdm;
   logic ack;
   realtime tl;

   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      act = 1'b0;
      rdm = 1'b0;
      starts = 0;
      tl = 0.0;
   end

   // ******************************
   // Framing and byte handling
   // ******************************
   always @(nack_n) nk = 0;

   always @(negedge sda) begin
      if (scl === 1'b1) begin
         act = 1'b1;
         bitc = -1;
         k = 0;
         sel = 1'b0;
         rdm = 1'b0;
         starts++;
      end
   end

   always @(posedge sda) begin
      if (scl === 1'b1) begin
         act = 1'b0;
         rdm = 1'b0;
         sda_pull = 1'b0;
      end
   end

   always @(posedge scl) begin
      if (act && bitc >= 0 && bitc < 8) sh = {sh[6:0], sda};
      if (act && bitc == 1) per_ns = int'($realtime - tl);
      tl = $realtime;
   end

   always @(negedge scl) begin
      if (act) begin
         if (bitc == 7) begin
            bitc = 8;
            ack = 1'b0;
            if (rdm) begin
               ack = 1'b0;
            end else if (k == 0) begin
               prev_b0 = b0;
               b0 = sh;
               rw = sh[0];
               ack = ten ? (sh[7:3] == 5'h1e && sh[2:1] == own[9:8]) : (sh[7:1] == own[6:0]);
               if (ack && nk < nack_n) begin
                  nk++;
                  ack = 1'b0;
               end
               sel = ack;
            end else if (k == 1 && ten) begin
               ack = sel && (sh == own[7:0]);
               sel = ack;
            end else if (sel && !rw) begin
               ack = 1'b1;
               rx = sh;
            end
            sda_pull = ack;
         end else if (bitc == 8) begin
            bitc = 0;
            k++;
            rdm = sel && rw && (k == (ten ? 2 : 1));
            sda_pull = rdm && !rd_byte[7];
         end else begin
            bitc++;
            sda_pull = rdm && !rd_byte[7 - bitc];
         end
      end
   end

   // Stretch on every low phase; the bench keeps it off in high speed
   always @(negedge scl) begin
      if (act && stretch_ns > 0) begin
         scl_pull = 1'b1;
         #(stretch_ns);
         scl_pull = 1'b0;
      end
   end
endmodule

// File: verification/two_wire_bus_master_tb.sv
// Purpose: Self-checking bench of the two-wire bus master
// Assumes: One slave model, pull-ups on both lines
// Notes:   Timeout shortened to 2000 cycles; the timeout case runs last
`timescale 1ns/1ps
`include "twm_consts.svh"
module two_wire_bus_master_tb;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic scl_o, scl_oe_n, sda_o, sda_oe_n, s_scl, s_sda, scl, sda, act, seen_busy;
   logic r_sda = 1'b0;
   logic [9:0] own = 10'h050;
   logic ten = 1'b0;
   logic [7:0] rd_byte = 8'ha5;
   logic [7:0] rx, b0, prev_b0;
   int nack_n = 0;
   int stretch_ns = 0;
   int starts, per_ns, s0;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [15:0] st, v;
   logic [7:0] ofs [6] = '{`TWM_OFS_CTRL, `TWM_OFS_ADDR, `TWM_OFS_TXD, `TWM_OFS_MCODE,
      `TWM_OFS_STAT, 8'h18};
   logic [15:0] rstv [6] = '{16'h0000, 16'h0000, 16'h0000, {13'h0000, `TWM_RST_MCODE},
      16'h0000, 16'h0000};

   // Open-drain lines: low if anyone pulls
   assign scl = (scl_oe_n === 1'b0 || s_scl === 1'b1) ? 1'b0 : 1'b1;
   assign sda = (sda_oe_n === 1'b0 || s_sda === 1'b1 || r_sda === 1'b1) ? 1'b0 : 1'b1;

   twm_master #(.TMO_CYC(2000)) dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
      .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));

   twm_slave_model slave (.scl(scl), .sda(sda), .scl_pull(s_scl), .sda_pull(s_sda),
      .own(own), .ten(ten), .rd_byte(rd_byte), .nack_n(nack_n), .stretch_ns(stretch_ns),
      .rx(rx), .b0(b0), .prev_b0(prev_b0), .starts(starts), .per_ns(per_ns), .act(act));

   // ******************************
   // Tasks
   // ******************************
   always #5 sys_clk = ~sys_clk;

   task automatic report_and_stop();
      $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
      @(posedge sys_clk);
   endtask

   // Start with GO; poll until a sticky flag shows and the master is idle
   task automatic run(input logic [15:0] ctrl);
      int n;
      n = 0;
      st = 16'h0000;
      seen_busy = 1'b0;
      s0 = starts;
      wr(`TWM_OFS_CTRL, ctrl | 16'h0001);
      while ((st[5:2] === 4'h0 || st[1] !== 1'b0) && n < 20000) begin
         rd(`TWM_OFS_STAT, st);
         seen_busy = seen_busy | (st[0] === 1'b1);
         n++;
      end
      if (n == 20000) begin
         err_total++;
         $display("Error at %0t: transfer did not finish", $time);
      end
      repeat (20) @(posedge sys_clk);
   endtask

   task automatic fin(input logic [3:0] m, input logic [3:0] e);
      chk({12'h000, st[5:2] & m}, {12'h000, e}, "status flags");
      wr(`TWM_OFS_STAT, 16'h003c);
      rd(`TWM_OFS_STAT, v);
      chk(v, 16'h0000, "status after clear");
   endtask

   task automatic chk_per(input int ns);
      chk({15'h0000, per_ns >= ns && per_ns <= ns + 60}, 16'h0001, "clock period");
   endtask

   always @(posedge sys_clk) begin
      cyc++;
      if (nrst && (scl_o !== 1'b0 || sda_o !== 1'b0)) begin
         err_total++;
         $display("Error at %0t: line driven high", $time);
      end
      if (cyc == 100000) begin
         err_total++;
         $display("Error at %0t: watchdog expired", $time);
         report_and_stop();
      end
   end

   // ******************************
   // Scenarios
   // ******************************
   initial begin
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      for (int i = 0; i < 6; i++) begin
         rd(ofs[i], v);
         chk(v, rstv[i], "reset value");
      end
      wr(8'h18, 16'hffff);
      rd(8'h18, v);
      chk(v, 16'h0000, "unmapped read");
      wr(`TWM_OFS_MCODE, 16'h0000);
      rd(`TWM_OFS_MCODE, v);
      chk(v, 16'h0001, "master code zero refused");
      wr(`TWM_OFS_MCODE, 16'h0005);
      wr(`TWM_OFS_CTRL, 16'h00fe);
      rd(`TWM_OFS_CTRL, v);
      chk(v, 16'h00fe, "control readback");
      ce <= 1'b0;
      wr(`TWM_OFS_TXD, 16'h0077);
      ce <= 1'b1;
      rd(`TWM_OFS_TXD, v);
      chk(v, 16'h0000, "write frozen by enable");
      // Write at 1M
      wr(`TWM_OFS_ADDR, 16'h0050);
      wr(`TWM_OFS_TXD, 16'h003c);
      run(16'h0080);
      fin(4'hf, 4'h1);
      chk({15'h0, seen_busy}, 16'h0001, "busy during transfer");
      chk(starts - s0, 1, "one start");
      chk({8'h00, b0}, 16'h00a0, "address byte");
      chk({8'h00, rx}, 16'h003c, "written byte");
      chk({15'h0, act}, 16'h0000, "stop seen");
      chk_per(1000);
      // Read at 400k
      run(16'h0044);
      fin(4'hf, 4'h1);
      chk({8'h00, b0}, 16'h00a1, "read address byte");
      wr(`TWM_OFS_RXD, 16'h0000);
      rd(`TWM_OFS_RXD, v);
      chk(v, 16'h00a5, "read byte");
      chk_per(2520);
      // Ten-bit write with a stretching slave
      own = 10'h2b7;
      ten = 1'b1;
      stretch_ns = 1500;
      wr(`TWM_OFS_ADDR, 16'h02b7);
      wr(`TWM_OFS_TXD, 16'h0096);
      run(16'h0082);
      fin(4'hf, 4'h1);
      chk({8'h00, b0}, 16'h00f4, "ten-bit first byte");
      chk({8'h00, rx}, 16'h0096, "data under stretch");
      own = 10'h050;
      ten = 1'b0;
      stretch_ns = 0;
      // Polling through two refusals
      nack_n = 2;
      wr(`TWM_OFS_ADDR, 16'h0050);
      wr(`TWM_OFS_TXD, 16'h005a);
      run(16'h0088);
      fin(4'hf, 4'h1);
      chk(starts - s0, 3, "polling starts");
      chk({8'h00, rx}, 16'h005a, "data after polling");
      nack_n = 0;
      // Unpolled refusal
      wr(`TWM_OFS_ADDR, 16'h0051);
      wr(`TWM_OFS_TXD, 16'h0011);
      run(16'h0080);
      fin(4'he, 4'h2);
      chk({8'h00, rx}, 16'h005a, "no data phase");
      chk({15'h0, act}, 16'h0000, "stop after refusal");
      // High speed with master code five
      wr(`TWM_OFS_ADDR, 16'h0050);
      wr(`TWM_OFS_TXD, 16'h00c3);
      run(16'h0090);
      fin(4'hf, 4'h1);
      chk({8'h00, prev_b0}, 16'h000d, "master code byte");
      chk({8'h00, b0}, 16'h00a0, "address after restart");
      chk({8'h00, rx}, 16'h00c3, "high speed data");
      chk_per(320);
      // SMBus caps the rate
      wr(`TWM_OFS_TXD, 16'h0081);
      run(16'h00a0);
      fin(4'hf, 4'h1);
      chk({8'h00, rx}, 16'h0081, "SMBus data");
      chk_per(10000);
      // Another master holds data low
      fork
         run(16'h0080);
         begin
            wait (sda === 1'b0);
            wait (scl === 1'b0);
            @(posedge sys_clk);
            r_sda <= 1'b1;
            repeat (400) @(posedge sys_clk);
            r_sda <= 1'b0;
         end
      join
      fin(4'h4, 4'h4);
      // Clock held low past the timeout; no stop follows
      stretch_ns = 30000;
      run(16'h00a0);
      chk({15'h0, st[5]}, 16'h0001, "timeout flag");
      chk({14'h0, scl_oe_n, sda_oe_n}, 16'h0003, "lines released");
      report_and_stop();
   end
endmodule
